/* rtl/acl_cfg.svh */
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH
// Register indices (byte address divided by four)
`define ACL_IDX_POWER 7'h01
`define ACL_IDX_COMP 7'h05
`define ACL_IDX_RATE 7'h07
`define ACL_IDX_CLOCK 7'h06
`define ACL_IDX_GPIO 7'h08
`define ACL_IDX_SYN_N 7'h24
`define ACL_IDX_SYN_K1 7'h25
`define ACL_IDX_SYN_K2 7'h26
`define ACL_IDX_SYN_K3 7'h27
// Field positions
`define ACL_BIT_SYNTH_EN 5
`define ACL_BIT_RETURN 0
`define ACL_ADC_LAW_LO 1
`define ACL_DAC_LAW_LO 3
`define ACL_RATE_LO 1
`define ACL_BIT_CLK_SRC 8
`define ACL_GPIO_SEL_LO 0
// Reset values
`define ACL_RST_POWER 9'h000
`define ACL_RST_COMP 9'h000
`define ACL_RST_RATE 9'h000
`define ACL_RST_CLOCK 9'h140
`define ACL_RST_GPIO 9'h000
`define ACL_RST_SYN_N 9'h008
`define ACL_RST_SYN_K1 9'h00c
`define ACL_RST_SYN_K2 9'h093
`define ACL_RST_SYN_K3 9'h0e9
// Law codes and pin function
`define ACL_LAW_OFF 2'h0
`define ACL_LAW_MU 2'h2
`define ACL_LAW_A 2'h3
`define ACL_PIN_SYNTH_CLK 3'h4
// Timing: one sample period is 256 master clock periods
`define ACL_MCLK_PER_FS 256
`define ACL_FIFO_DEPTH 8
`endif

/* rtl/acl_pkg.sv */
`default_nettype none
package acl_pkg;
   typedef enum logic [1:0]
   {
      ACL_LAW_OFF_E = 2'b00,
      ACL_LAW_RSV_E = 2'b01,
      ACL_LAW_MU_E = 2'b10,
      ACL_LAW_A_E = 2'b11
   } acl_law_type;
   typedef enum logic [2:0]
   {
      ACL_FS48_E = 3'b000,
      ACL_FS32_E = 3'b001,
      ACL_FS24_E = 3'b010,
      ACL_FS16_E = 3'b011,
      ACL_FS12_E = 3'b100,
      ACL_FS8_E = 3'b101,
      ACL_FS_RSV6_E = 3'b110,
      ACL_FS_RSV7_E = 3'b111
   } acl_rate_type;
   typedef enum logic [0:0]
   {
      ACL_WB_IDLE_E = 1'b0,
      ACL_WB_ACK_E = 1'b1
   } acl_wb_type;
endpackage
`default_nettype wire

/* rtl/acl_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module acl_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } acl_fifo_state_type;
   acl_fifo_state_type st;
   acl_fifo_state_type next_st;
   logic push;
   logic pop;
   assign in_ready_o = (st.count != (AW+1)'(DEPTH));
   assign out_valid_o = (st.count != '0);
   assign out_data_o = st.mem[st.rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wr] = in_data_i;
         next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
      end
      if (pop)
      begin
         next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
      end
      if (push && !pop)
      begin
         next_st.count = st.count + 1'b1;
      end
      else if (pop && !push)
      begin
         next_st.count = st.count - 1'b1;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

/* rtl/acl_codec.sv */
`timescale 1ns/10ps
`default_nettype none
`include "acl_cfg.svh"
// Combinational G.711 compressor and expander for one 16-bit word
module acl_codec
(
   input wire logic [1:0] enc_law_i,
   input wire logic [15:0] enc_lin_i,
   output logic [7:0] enc_code_o,
   input wire logic [1:0] dec_law_i,
   input wire logic [7:0] dec_code_i,
   output logic [15:0] dec_lin_o
);
   // Segment: position of the highest set bit among bits 12..6 of a magnitude, minus five (0 if none)
   function automatic logic [2:0] seg_of(input logic [12:0] mag);
      logic [2:0] s;
      s = 3'h0;
      for (int i = 1; i < 8; i++)
      begin
         if (mag[i+5])
         begin
            s = 3'(i);
         end
      end
      return s;
   endfunction
   logic [7:0] code;
   logic [15:0] lin;
   always_comb
   begin
      logic [12:0] mag;
      logic [2:0] seg;
      logic [3:0] man;
      logic sgn;
      mag = '0;
      seg = '0;
      man = '0;
      sgn = enc_lin_i[15];
      // Eight segments, finer steps near zero
      if (enc_law_i == `ACL_LAW_MU)
      begin
         mag = {(sgn ? ~enc_lin_i[14:3] : enc_lin_i[14:3]), 1'b0};
         mag = (mag > 13'h1f5f) ? 13'h1fdf : mag + 13'h0021;
         seg = seg_of(mag);
         man = mag[seg+1 +: 4];
         code = ~{sgn, seg, man};
      end
      else
      begin
         mag = {(sgn ? ~enc_lin_i[14:4] : enc_lin_i[14:4]), 2'h0};
         seg = seg_of(mag);
         man = (seg == 3'h0) ? mag[5:2] : mag[seg+1 +: 4];
         code = {~sgn, seg, man} ^ 8'h55;
      end
      enc_code_o = code;
   end
   always_comb
   begin
      logic [7:0] c;
      logic [12:0] m;
      c = '0;
      m = '0;
      if (dec_law_i == `ACL_LAW_MU)
      begin
         c = ~dec_code_i;
         m = 13'(({9'h000, c[3:0], 1'b1} + 14'h0020) << c[6:4]) - 13'h0021;
         lin = c[7] ? 16'(~{1'b0, m, 2'h0}) : {1'b0, m, 2'h0};
      end
      else
      begin
         c = dec_code_i ^ 8'h55;
         if (c[6:4] == 3'h0)
         begin
            m = {7'h00, c[3:0], 2'h2};
         end
         else
         begin
            m = 13'({8'h01, c[3:0], 1'b1} << (c[6:4] - 3'h1)) << 1;
         end
         lin = c[7] ? {1'b0, m[12:1], 3'h0} : 16'(~{1'b0, m[12:1], 3'h0});
      end
      dec_lin_o = lin;
   end
endmodule
`default_nettype wire

/* rtl/acl_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "acl_cfg.svh"
module acl_top
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = `ACL_FIFO_DEPTH
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic adc_valid_i,
   output logic adc_ready_o,
   input wire logic [15:0] adc_data_i,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [15:0] tx_data_o,
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   input wire logic [15:0] rx_data_i,
   output logic dac_valid_o,
   input wire logic dac_ready_i,
   output logic [15:0] dac_data_o,
   input wire logic ext_mclk_i,
   input wire logic synth_clk_i,
   output logic core_mclk_o,
   output logic synth_enable_o,
   output logic [3:0] synth_integer_o,
   output logic [23:0] synth_fraction_o,
   output logic [2:0] rate_code_o,
   output logic chipsel_multi_pin_o,
   output logic chipsel_multi_pin_oe_o
);
   typedef struct packed
   {
      acl_pkg::acl_wb_type wb;
      logic [31:0] rdata;
      logic [8:0] power;
      logic [8:0] comp;
      logic [8:0] rate;
      logic [8:0] clock;
      logic [8:0] gpio;
      logic [8:0] syn_n;
      logic [8:0] syn_k1;
      logic [8:0] syn_k2;
      logic [8:0] syn_k3;
      logic tx_full;
      logic [15:0] tx_word;
      logic dac_full;
      logic [15:0] dac_word;
   } acl_state_type;
   acl_state_type st;
   acl_state_type next_st;

   // Register index decode, shared by read and write
   function automatic logic [6:0] reg_index(input logic [31:0] a);
      return a[8:2];
   endfunction

   logic [7:0] enc_code;
   logic [15:0] dec_lin;
   logic [15:0] fifo_out;
   logic fifo_valid;
   logic fifo_ready;
   logic src_valid;
   logic [15:0] src_word;
   logic [15:0] rx_word;
   logic rx_take;
   logic loop_on;
   logic tx_take;
   logic [1:0] adc_law;
   logic [1:0] dac_law;
   logic wb_req;

   // ------------------------------------------------------------
   // Receive FIFO in front of the DAC path
   // ------------------------------------------------------------
   acl_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(src_valid),
      .in_ready_o(fifo_ready),
      .in_data_i(src_word),
      .out_valid_o(fifo_valid),
      .out_ready_i(!st.dac_full || dac_ready_i),
      .out_data_o(fifo_out)
   );

   acl_codec u_codec
   (
      .enc_law_i(adc_law),
      .enc_lin_i(adc_data_i),
      .enc_code_o(enc_code),
      .dec_law_i(dac_law),
      .dec_code_i(fifo_out[15:8]),
      .dec_lin_o(dec_lin)
   );

   // ------------------------------------------------------------
   // Data path
   // ------------------------------------------------------------
   assign loop_on = st.comp[`ACL_BIT_RETURN];
   assign adc_law = st.comp[`ACL_ADC_LAW_LO +: 2];
   assign dac_law = st.comp[`ACL_DAC_LAW_LO +: 2];
   assign tx_take = !st.tx_full || (tx_ready_i && !loop_on);
   assign adc_ready_o = loop_on ? (!st.tx_full || fifo_ready) : tx_take;
   assign tx_valid_o = st.tx_full && !loop_on;
   assign tx_data_o = st.tx_word;
   // Loop feeds the interface-format word into the receive side
   assign src_valid = loop_on ? st.tx_full : rx_valid_i;
   assign src_word = loop_on ? st.tx_word : rx_data_i;
   assign rx_ready_o = loop_on ? 1'b0 : fifo_ready;
   assign rx_take = !st.dac_full || dac_ready_i;
   assign rx_word = (dac_law[1]) ? dec_lin : fifo_out;
   assign dac_valid_o = st.dac_full;
   assign dac_data_o = st.dac_word;

   // ------------------------------------------------------------
   // Clock selection and synth outputs
   // ------------------------------------------------------------
   assign core_mclk_o = st.clock[`ACL_BIT_CLK_SRC] ? synth_clk_i
                                                    : ext_mclk_i;
   assign synth_enable_o = st.power[`ACL_BIT_SYNTH_EN];
   assign synth_integer_o = st.syn_n[3:0];
   assign synth_fraction_o = {st.syn_k1[5:0], st.syn_k2, st.syn_k3};
   assign rate_code_o = st.rate[`ACL_RATE_LO +: 3];
   assign chipsel_multi_pin_oe_o =
      (st.gpio[`ACL_GPIO_SEL_LO +: 3] == `ACL_PIN_SYNTH_CLK);
   assign chipsel_multi_pin_o = chipsel_multi_pin_oe_o &&
                                (synth_clk_i ^ st.gpio[3]);

   // ------------------------------------------------------------
   // Wishbone slave, one wait state
   // ------------------------------------------------------------
   assign wb_req = wb_cyc_i && wb_stb_i;
   assign wb_ack_o = (st.wb == acl_pkg::ACL_WB_ACK_E);
   assign wb_dat_o = st.rdata;

   always_comb
   begin
      logic [8:0] wd;
      logic [8:0] rd;
      wd = {wb_sel_i[1] ? wb_dat_i[8] : 1'b0, wb_dat_i[7:0]};
      rd = 9'h000;
      next_st = st;
      case (reg_index(wb_adr_i))
         `ACL_IDX_POWER: rd = st.power;
         `ACL_IDX_COMP: rd = st.comp;
         `ACL_IDX_RATE: rd = st.rate;
         `ACL_IDX_CLOCK: rd = st.clock;
         `ACL_IDX_GPIO: rd = st.gpio;
         `ACL_IDX_SYN_N: rd = st.syn_n;
         `ACL_IDX_SYN_K1: rd = st.syn_k1;
         `ACL_IDX_SYN_K2: rd = st.syn_k2;
         `ACL_IDX_SYN_K3: rd = st.syn_k3;
         default: rd = 9'h000;
      endcase
      case (st.wb)
         acl_pkg::ACL_WB_IDLE_E:
         begin
            if (wb_req)
            begin
               next_st.wb = acl_pkg::ACL_WB_ACK_E;
               next_st.rdata = {23'h000000, rd};
               if (wb_we_i && wb_sel_i[0])
               begin
                  if (!wb_sel_i[1])
                  begin
                     wd[8] = rd[8];
                  end
                  case (reg_index(wb_adr_i))
                     `ACL_IDX_POWER: next_st.power = wd;
                     `ACL_IDX_COMP: next_st.comp = wd;
                     `ACL_IDX_RATE: next_st.rate = wd;
                     `ACL_IDX_CLOCK: next_st.clock = wd;
                     `ACL_IDX_GPIO: next_st.gpio = wd;
                     `ACL_IDX_SYN_N: next_st.syn_n = wd;
                     `ACL_IDX_SYN_K1: next_st.syn_k1 = wd;
                     `ACL_IDX_SYN_K2: next_st.syn_k2 = wd;
                     `ACL_IDX_SYN_K3: next_st.syn_k3 = wd;
                     default: next_st.power = st.power;
                  endcase
               end
            end
         end
         acl_pkg::ACL_WB_ACK_E: next_st.wb = acl_pkg::ACL_WB_IDLE_E;
         default: next_st.wb = acl_pkg::ACL_WB_IDLE_E;
      endcase
      // Transmit stage: with mu or A law, code in top byte, zeros below; with law off, the word unchanged
      if (loop_on && st.tx_full && fifo_ready)
      begin
         next_st.tx_full = 1'b0;
      end
      else if (tx_valid_o && tx_ready_i)
      begin
         next_st.tx_full = 1'b0;
      end
      if (adc_valid_i && adc_ready_o)
      begin
         next_st.tx_full = 1'b1;
         next_st.tx_word = adc_law[1] ? {enc_code, 8'h00}
                                      : adc_data_i;
      end
      // DAC stage
      if (st.dac_full && dac_ready_i)
      begin
         next_st.dac_full = 1'b0;
      end
      if (fifo_valid && rx_take)
      begin
         next_st.dac_full = 1'b1;
         next_st.dac_word = rx_word;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st <= '0;
         st.power <= `ACL_RST_POWER;
         st.comp <= `ACL_RST_COMP;
         st.rate <= `ACL_RST_RATE;
         st.clock <= `ACL_RST_CLOCK;
         st.gpio <= `ACL_RST_GPIO;
         st.syn_n <= `ACL_RST_SYN_N;
         st.syn_k1 <= `ACL_RST_SYN_K1;
         st.syn_k2 <= `ACL_RST_SYN_K2;
         st.syn_k3 <= `ACL_RST_SYN_K3;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_synth_off_reset: assert property (@(posedge clk_i)
      $fell(rst_i) |-> !synth_enable_o)
      else $error("synth enable not off after reset");
   chk_clock_src_reset: assert property (@(posedge clk_i)
      $fell(rst_i) |-> st.clock[`ACL_BIT_CLK_SRC])
      else $error("clock source not synth after reset");
   chk_loop_no_tx: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_on |-> !tx_valid_o && !rx_ready_o)
      else $error("transmit active during loop");
   chk_loop_source: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_on |-> src_word == st.tx_word)
      else $error("loop source wrong");
   chk_code_msb: assert property (@(posedge clk_i) disable iff (rst_i)
      adc_valid_i && adc_ready_o && adc_law[1] |=>
      tx_data_o[7:0] == 8'h00)
      else $error("code not in top byte");
   chk_plain_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      adc_valid_i && adc_ready_o && adc_law == `ACL_LAW_OFF |=>
      tx_data_o == $past(adc_data_i))
      else $error("plain word altered");
   chk_wb_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   chk_wb_ack_time: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_req && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_mu_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      adc_law == `ACL_LAW_MU && adc_data_i == 16'h0000 |->
      enc_code == 8'hff)
      else $error("mu zero code wrong");
endmodule
`default_nettype wire

/* sim/acl_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acl_host_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stall_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic [15:0] tx_data_i,
   output logic rx_valid_o = 1'h0,
   input wire logic rx_ready_i,
   output logic [15:0] rx_data_o = 16'h0
);
   logic [15:0] got_q[$];
   logic slow = 1'h0;
   // Slow mode takes a transmit word only every other cycle
   assign tx_ready_o = !rst_i && !(stall_i && slow);
   always @(posedge clk_i)
   begin
      slow <= !slow;
      if (tx_valid_i && tx_ready_o)
         got_q.push_back(tx_data_i);
   end
   // Code byte rides in the top byte; a released lane shows the inverse
   task automatic send(input logic [15:0] w, input int lim, output logic ok);
      int n;
      rx_valid_o <= 1'h1;
      rx_data_o <= w;
      n = 0;
      do @(posedge clk_i); while (rx_ready_i !== 1'h1 && ++n < lim);
      ok = rx_ready_i === 1'h1;
      rx_valid_o <= 1'h0;
      rx_data_o <= ~w;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

/* sim/acl_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module acl_top_tb;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, r;
   logic [3:0] wb_sel_i = 4'hf;
   logic adc_valid_i = 1'h0, dac_ready_i = 1'h0, stall = 1'h0, ok;
   logic ext_mclk_i = 1'h0, synth_clk_i = 1'h0;
   logic [15:0] adc_data_i = 16'h0, tx_data_o, rx_data_i, dac_data_o, t, y, z;
   logic adc_ready_o, tx_valid_o, tx_ready_i, rx_valid_i, rx_ready_o;
   logic dac_valid_o, core_mclk_o, synth_enable_o;
   logic chipsel_multi_pin_o, chipsel_multi_pin_oe_o;
   logic [3:0] synth_integer_o;
   logic [23:0] synth_fraction_o;
   logic [2:0] rate_code_o;
   int mismatches = 0, samples_checked = 0;
   acl_top u_acl_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .adc_valid_i,
      .adc_ready_o, .adc_data_i, .tx_valid_o, .tx_ready_i, .tx_data_o,
      .rx_valid_i, .rx_ready_o, .rx_data_i, .dac_valid_o, .dac_ready_i,
      .dac_data_o, .ext_mclk_i, .synth_clk_i, .core_mclk_o, .synth_enable_o,
      .synth_integer_o, .synth_fraction_o, .rate_code_o,
      .chipsel_multi_pin_o, .chipsel_multi_pin_oe_o);
   acl_host_model u_acl_host_model (.clk_i, .rst_i, .stall_i(stall),
      .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .tx_data_i(tx_data_o),
      .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o), .rx_data_o(rx_data_i));
   initial
   begin
      forever #25 clk_i = ~clk_i;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: %s got %h", $time, m, got);
      end
   endtask
   task automatic check_mag(input logic [15:0] w, lo, hi, input string m);
      logic [16:0] a;
      a = w[15] ? 17'h10000 - w : {1'h0, w};
      check(a >= lo && a <= hi, 32'h1, m);
   endtask
   task automatic bound(input int n);
      if (n >= 100)
      begin
         check(32'h0, 32'h1, "timeout");
         wrap_up();
      end
   endtask
   task automatic wb(input logic we, input logic [31:0] a, d);
      int n;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++n < 100);
      bound(n);
      r = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic adc_push(input logic [15:0] w);
      int n;
      adc_valid_i <= 1'h1;
      adc_data_i <= w;
      n = 0;
      do @(posedge clk_i); while (adc_ready_o !== 1'h1 && ++n < 100);
      bound(n);
      adc_valid_i <= 1'h0;
      adc_data_i <= ~w;
      @(posedge clk_i);
   endtask
   task automatic dac_get();
      int n;
      dac_ready_i <= 1'h1;
      n = 0;
      do @(posedge clk_i); while (dac_valid_o !== 1'h1 && ++n < 100);
      bound(n);
      y = dac_data_o;
      dac_ready_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic tx_word(input logic [15:0] w);
      int n;
      adc_push(w);
      for (n = 0; n < 100 && u_acl_host_model.got_q.size() == 0; n++)
         @(posedge clk_i);
      bound(n);
      t = u_acl_host_model.got_q.pop_front();
   endtask
   task automatic rx_word(input logic [15:0] w);
      u_acl_host_model.send(w, 100, ok);
      check(ok, 32'h1, "rx refused");
      dac_get();
   endtask
   task automatic t_regs();
      logic [31:0] a[9] = '{32'h04, 32'h14, 32'h1c, 32'h18, 32'h90,
         32'h94, 32'h98, 32'h9c, 32'h40};
      logic [31:0] e[9] = '{32'h0, 32'h0, 32'h0, 32'h140, 32'h8, 32'hc,
         32'h93, 32'he9, 32'h0};
      wb(1'h1, 32'h40, 32'h1ff);
      for (int i = 0; i < 9; i++)
      begin
         wb(1'h0, a[i], 32'h0);
         check(r, e[i], "reset value");
      end
      check(synth_enable_o, 32'h0, "synth off");
   endtask
   task automatic t_synth();
      wb(1'h1, 32'h04, 32'h020);
      check(synth_enable_o, 32'h1, "synth on");
      wb(1'h1, 32'h90, 32'h7);
      wb(1'h1, 32'h94, 32'h21);
      wb(1'h1, 32'h98, 32'h161);
      wb(1'h1, 32'h9c, 32'h27);
      check(synth_integer_o, 32'h7, "integer");
      check(synth_fraction_o, 32'h86c227, "fraction");
      wb(1'h1, 32'h04, 32'h0);
      check(synth_enable_o, 32'h0, "synth off");
      for (int c = 0; c < 6; c++)
      begin
         wb(1'h1, 32'h1c, 32'(c << 1));
         check(rate_code_o, 32'(c), "rate");
      end
   endtask
   task automatic t_clk();
      for (int i = 0; i < 4; i++)
      begin
         if (i == 2)
            wb(1'h1, 32'h18, 32'h040);
         ext_mclk_i <= i[0];
         synth_clk_i <= ~i[0];
         @(posedge clk_i);
         check(core_mclk_o, 32'(i[0] ^ (i < 2)), "core clock");
      end
      wb(1'h1, 32'h20, 32'h4);
      synth_clk_i <= 1'h1;
      @(posedge clk_i);
      check({chipsel_multi_pin_oe_o, chipsel_multi_pin_o}, 32'h3, "pin");
      wb(1'h1, 32'h20, 32'hc);
      check({chipsel_multi_pin_oe_o, chipsel_multi_pin_o}, 32'h2, "pin");
      wb(1'h1, 32'h20, 32'h0);
      check(chipsel_multi_pin_oe_o, 32'h0, "pin off");
   endtask
   task automatic t_codec();
      wb(1'h1, 32'h14, 32'h1c);
      tx_word(16'h0);
      check(t & 16'h7fff, 32'h7f00, "mu zero");
      rx_word(16'hd500);
      check_mag(y, 16'h1, 16'h3f, "a small");
      rx_word(16'h2a00);
      check_mag(y, 16'h7000, 16'h8000, "a large");
      wb(1'h1, 32'h14, 32'h16);
      tx_word(16'h0);
      check(t & 16'h7fff, 32'h5500, "a zero");
      rx_word(16'hff00);
      check(y, 32'h0, "mu zero");
      rx_word(16'h7f00);
      check(y, 32'hffff, "mu negative zero");
      rx_word(16'h8000);
      check_mag(y, 16'h7000, 16'h8000, "mu large");
      for (int k = 0; k < 2; k++)
      begin
         stall <= k[0];
         wb(1'h1, 32'h14, k ? 32'h1e : 32'h14);
         for (int c = 0; c < 256; c++)
            if (k || c[6:0] != 7'h7f)
            begin
               rx_word({c[7:0], 8'h0});
               tx_word(y);
               check(t, {c[7:0], 8'h0}, "round trip");
            end
      end
      stall <= 1'h0;
   endtask
   task automatic t_loop();
      wb(1'h1, 32'h14, 32'h1);
      adc_push(16'h1234);
      dac_get();
      check(y, 32'h1234, "looped word");
      check({tx_valid_o, rx_ready_o}, 32'h0, "lanes");
      check(u_acl_host_model.got_q.size(), 32'h0, "tx");
      wb(1'h1, 32'h14, 32'h14);
      tx_word(16'h1234);
      rx_word(t);
      z = y;
      wb(1'h1, 32'h14, 32'h15);
      adc_push(16'h1234);
      dac_get();
      check(y, z, "looped code");
   endtask
   task automatic t_fifo();
      int cnt;
      wb(1'h1, 32'h14, 32'h0);
      cnt = 0;
      ok = 1'h1;
      while (ok && cnt < 12)
      begin
         u_acl_host_model.send(16'(cnt * 257), 4, ok);
         cnt += ok;
      end
      check(cnt inside {8, 9}, 32'h1, "fill depth");
      for (int i = 0; i < cnt; i++)
      begin
         dac_get();
         check(y, 32'(16'(i * 257)), "drain order");
      end
      check(dac_valid_o, 32'h0, "drained");
   endtask
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      t_regs();
      t_synth();
      t_clk();
      t_codec();
      t_loop();
      t_fifo();
      wrap_up();
   end
endmodule
`default_nettype wire
